/* sim/spi_host.sv */
// Serial host model standing in for the microcontroller.
// Assumes the bench calls send() once at a time; clock runs only in frames.
`timescale 1ns/100ps
module spi_host (
   // Serial pins
   output logic sck_o,
   output logic cs_n_o,
   output logic mosi_o
);
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // ********
   // One frame, MSB first, 15 ns bit clock
   // ********
   task automatic send(input logic [15:0] f);
      #3.3;
      cs_n_o = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         mosi_o = f[i];
         #7.5;
         sck_o = 1'b1;
         #7.5;
         sck_o = 1'b0;
      end
      #7.5;
      cs_n_o = 1'b1;
      mosi_o = ~f[0];
      #150;
   endtask : send
endmodule : spi_host

/* sim/tb.sv */
// Self-checking bench for the watchdog supervisor.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/100ps
`include "wdog_defines.svh"
module tb;
   localparam int TICK = 10;
   localparam int DLY = 4;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic sck, cs_n, mosi, rst_n, rreq, nreq, step1, sfail, run, irq, can_lo, lin_lo;
   logic dev = 1'b0, fid = 1'b0, evt = 1'b0, clr = 1'b0;
   logic [1:0] wk = 2'h0;
   logic [1:0] flags;
   logic [15:0] cur;
   wdog_pkg::sbc_mode_t mode = wdog_pkg::MODE_INIT;
   wdog_pkg::supervisor_ctrl_t ctrl;
   int n_mismatch = 0;
   int check_count = 0;
   int falls = 0;
   int n, n0, p;
   int ms_tab[8] = '{10, 20, 50, 100, 200, 500, 1000, 1000};
   spi_host i_spi_host (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));
   window_timeout_watchdog #(.TICK_CYCLES(TICK), .RESET_DELAY_CYCLES(DLY), .LONG_WINDOW_MS(10))
   i_window_timeout_watchdog (.clk_i(clk_i), .rstn_i(rstn_i), .spi_clk_i(sck),
      .chip_select_n_i(cs_n), .spi_data_i(mosi), .sbc_mode_i(mode), .dev_mode_i(dev),
      .fail_input_disable_i(fid), .reset_event_i(evt), .can_wake_i(wk[1]), .lin_wake_i(wk[0]),
      .spi_fail_clear_i(clr), .reset_out_n_o(rst_n), .restart_req_o(rreq), .normal_req_o(nreq),
      .ctrl_o(ctrl), .stop_disable_step_one_o(step1), .service_failure_flags_o(flags),
      .spi_fail_o(sfail), .watchdog_running_o(run), .wake_irq_o(irq),
      .can_receive_low_o(can_lo), .lin_receive_low_o(lin_lo));
   initial forever #12.5 clk_i = ~clk_i;
   // Mode controller reacting to the supervisor's requests
   always @(posedge clk_i) begin
      if (rreq === 1'b1) mode <= wdog_pkg::MODE_RESTART;
      else if (nreq === 1'b1) mode <= wdog_pkg::MODE_NORMAL;
   end
   always @(negedge rst_n) falls++;
   // ********
   // Helpers
   // ********
   function automatic logic [15:0] cfg(input logic [2:0] per, input logic [3:0] b, input logic bad);
      logic [6:0] d;
      d = {per, b};
      return {(^d) ^ bad, d, 1'b1, `ADDR_SUPERVISOR_CTRL};
   endfunction : cfg
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %0h, want %0h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
      #2;
   endtask : cyc
   task automatic wait_rst(input logic lvl, input int lim);
      n = 0;
      while (rst_n !== lvl && n < lim) begin
         cyc(1);
         n++;
      end
   endtask : wait_rst
   task automatic serve(input logic [15:0] f);
      cur = f;
      i_spi_host.send(f);
   endtask : serve
   task automatic results;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   initial begin
      #1500000;
      n_mismatch++;
      results();
   end
   // ********
   // Main sequence
   // ********
   initial begin
      void'($urandom(90485));
      cyc(4);
      rstn_i = 1'b1;
      check(ctrl, 8'h40);
      check(rst_n, 1'b1);
      mode = wdog_pkg::MODE_NORMAL;
      serve(cfg(3'h1, 4'h0, 1'b0));
      check(ctrl, cur[15:8]);
      i_spi_host.send(cfg(3'h0, 4'h2, 1'b1));
      check(ctrl, cur[15:8]);
      check(sfail, 1'b1);
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(2);
      check(sfail, 1'b0);
      n0 = falls;
      repeat (12) begin
         cyc($urandom_range(20, 150));
         serve(cur);
      end
      check(falls, n0);
      for (int c = 0; c < 7; c++) begin
         serve(cfg(c[2:0], 4'h0, 1'b0));
         check(ctrl, cur[15:8]);
         p = ms_tab[c] * TICK;
         wait_rst(1'b0, 20000);
         check(n + 8 > p && n < p + 4, 1'b1);
         wait_rst(1'b1, 200);
         check(flags, 2'h1);
      end
      serve(cfg(3'h0, 4'h2, 1'b0));
      n0 = falls;
      repeat (5) begin
         cyc($urandom_range(50, 70));
         serve(cur);
      end
      check(falls, n0);
      cyc(5);
      serve(cur);
      wait_rst(1'b0, 100);
      check(n < 30, 1'b1);
      wait_rst(1'b1, 200);
      serve(cfg(3'h4, 4'h1, 1'b0));
      check(ctrl[0], 1'b0);
      fid = 1'b1;
      i_spi_host.send({8'h01, 1'b1, `ADDR_WAKE_CTRL_ONE});
      check(step1, 1'b0);
      serve(cfg(3'h4, 4'h5, 1'b0));
      i_spi_host.send({8'h01, 1'b1, `ADDR_WAKE_CTRL_ONE});
      check(step1, 1'b1);
      mode = wdog_pkg::MODE_STOP;
      cyc(5);
      check(run, 1'b0);
      wk = 2'h2;
      cyc(1);
      wk = 2'h0;
      n = 0;
      while (irq !== 1'b1 && n < 10) begin
         cyc(1);
         n++;
      end
      check(n < 10, 1'b1);
      cyc(2);
      check({can_lo, lin_lo, run, step1, ctrl[0]}, 5'h14);
      mode = wdog_pkg::MODE_NORMAL;
      serve(cfg(3'h4, 4'h4, 1'b0));
      check({can_lo, step1}, 2'h0);
      dev = 1'b1;
      n0 = falls;
      cyc(2500);
      check(falls, n0);
      check(run, 1'b0);
      dev = 1'b0;
      serve(cur);
      evt = 1'b1;
      cyc(6);
      check(rst_n, 1'b0);
      evt = 1'b0;
      wait_rst(1'b1, 50);
      check(n >= DLY && n <= DLY + 3, 1'b1);
      serve(cfg(3'h0, 4'h8, 1'b0));
      n0 = falls;
      cyc(3000);
      check(falls - n0, 3);
      check(flags, 2'h3);
      results();
   end
endmodule : tb
bind window_timeout_watchdog wdog_chk #(.RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)) i_wdog_chk (
   .clk_i(clk_i), .rstn_i(rstn_i), .chip_select_n_i(chip_select_n_i), .sbc_mode_i(sbc_mode_i),
   .dev_mode_i(dev_mode_i), .reset_event_i(reset_event_i), .spi_fail_clear_i(spi_fail_clear_i),
   .reset_out_n_o(reset_out_n_o), .restart_req_o(restart_req_o), .normal_req_o(normal_req_o),
   .ctrl_o(ctrl_o), .spi_fail_o(spi_fail_o), .watchdog_running_o(watchdog_running_o),
   .wake_irq_o(wake_irq_o));

/* sim/wdog_chk.sv */
// Concurrent checks on the watchdog supervisor ports.
// Assumes it is bound into window_timeout_watchdog from the bench top.
`timescale 1ns/100ps
module wdog_chk #(
   parameter int RESET_DELAY_CYCLES = 4
) (
   // Clock, reset and serial select
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic chip_select_n_i,
   // Device context
   input wire wdog_pkg::sbc_mode_t sbc_mode_i,
   input wire logic dev_mode_i,
   input wire logic reset_event_i,
   input wire logic spi_fail_clear_i,
   // Watched outputs
   input wire logic reset_out_n_o,
   input wire logic restart_req_o,
   input wire logic normal_req_o,
   input wire wdog_pkg::supervisor_ctrl_t ctrl_o,
   input wire logic spi_fail_o,
   input wire logic watchdog_running_o,
   input wire logic wake_irq_o
);
   logic [15:0] low_cnt;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // ********
   // Length of the current reset pulse
   // ********
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         low_cnt <= 16'h0;
      end else if (reset_out_n_o) begin
         low_cnt <= 16'h0;
      end else if (low_cnt != 16'hffff) begin
         low_cnt <= low_cnt + 16'h1;
      end
   end
   // ********
   // Assertions
   // ********
   fail_edge_a: assert property (restart_req_o |-> !reset_out_n_o)
      else $error("restart request without reset low");
   fail_pulse_a: assert property (restart_req_o |=> !restart_req_o)
      else $error("restart request longer than one cycle");
   release_norm_a: assert property ($rose(reset_out_n_o) |-> ##[0:1] normal_req_o)
      else $error("reset release without normal request");
   hold_time_a: assert property ($rose(reset_out_n_o) |-> low_cnt >= RESET_DELAY_CYCLES)
      else $error("reset pulse shorter than the delay");
   dev_quiet_a: assert property (dev_mode_i [*2] |-> !watchdog_running_o && !restart_req_o)
      else $error("watchdog active in development mode");
   event_low_a: assert property (reset_event_i [*3] |-> !reset_out_n_o)
      else $error("reset released while event present");
   ctrl_take_a: assert property ($changed(ctrl_o[6:1]) |->
      chip_select_n_i && $past(chip_select_n_i, 2))
      else $error("settings changed before select rise");
   ctrl_frozen_a: assert property ((sbc_mode_i != wdog_pkg::MODE_NORMAL) [*3] |->
      $stable(ctrl_o[6:1]))
      else $error("settings changed outside normal mode");
   fail_sticky_a: assert property (spi_fail_o && !spi_fail_clear_i |=> spi_fail_o)
      else $error("serial error flag dropped without clear");
   fail_cov: cover property (restart_req_o);
   wake_cov: cover property (wake_irq_o);
   parity_cov: cover property ($rose(spi_fail_o));
endmodule : wdog_chk

/* src/wdog_defines.svh */
// Constants for the window/time-out watchdog supervisor.
// Assumes a 16-bit serial frame, data byte in the upper half.
`ifndef WDOG_DEFINES_SVH
`define WDOG_DEFINES_SVH

// ****************************************************************
// Serial frame layout
// ****************************************************************
`define FRAME_BITS 5'h10
`define FRAME_WRITE_BIT 7
`define ADDR_SUPERVISOR_CTRL 7'h15
`define ADDR_WAKE_CTRL_ONE 7'h05

// ****************************************************************
// Register fields and reset values
// ****************************************************************
`define WAKE_STEP_ONE_BIT 0
`define CTRL_RESET 8'h40
`define PERIOD_RESET 3'h4

// ****************************************************************
// Timing and failure limit
// ****************************************************************
`define CLK_MHZ 40
`define TICK_TIME_US 1000
`define RESET_DELAY_US 10
`define LONG_WINDOW_MS 200
`define CLOSED_PERCENT 60
`define FAIL_LIMIT 2'h3

`endif

/* src/wdog_pkg.sv */
// Types shared by the watchdog supervisor and its surroundings.
// Assumes the mode controller drives the device mode as sbc_mode_t.
package wdog_pkg;

   typedef enum logic [2:0] {
      MODE_INIT,
      MODE_NORMAL,
      MODE_STOP,
      MODE_SLEEP,
      MODE_RESTART,
      MODE_FAIL_SAFE
   } sbc_mode_t;

   typedef enum {
      WD_OFF,
      WD_LONG,
      WD_CLOSED,
      WD_OPEN,
      WD_RESET
   } wd_state_t;

   typedef struct packed {
      logic parity_result;
      logic [2:0] period_select_field;
      logic reset_limit;
      logic restart_on_bus_wake;
      logic window_variant_select;
      logic stop_disable_step_zero;
   } supervisor_ctrl_t;

endpackage : wdog_pkg

/* src/window_timeout_watchdog.sv */
// Watchdog supervisor: serial service port, time-out and window variants,
// reset output with delay, stop-mode disable sequence, bus-wake restart.
// Assumes mode, wake and reset-event inputs come from logic on clk_i;
// spi_clk_i is the host's serial clock, stopped outside frames.
// Functional notes
// - Single bit picks time-out or window variant
// - Settings change only in normal mode
// - Init starts long window; stop fixed or off
// - Sleep/restart/fail-safe off; long window afterwards
// - Valid control write serves at chip-select rise
// - New timing restarts timer immediately
// - Seven periods, 10 to 1000 ms, 200 default
// - Failure: restart mode, flags, then long window
// - Development mode keeps watchdog off
// - After three resets, limit bit suppresses resets
// - Time-out: service anytime restarts period
// - Time-out expiry drives reset low
// - Window: 60% closed then open window
// - Early service or expiry drives reset low
// - Control write needs even parity, eight bits
// - Parity error discards write, sets error flag
// - Disable sequence needs fail input disabled
// - Two enable bits; error clears second bit
// - Stop service or normal re-enables watchdog
// - Restarting sequence clears set first bit
// - Bus wake in stop restarts watchdog
// - Reset held for event plus delay
`timescale 1ns/100ps
`include "wdog_defines.svh"

module window_timeout_watchdog #(
   parameter int TICK_CYCLES = `TICK_TIME_US * `CLK_MHZ,
   parameter int RESET_DELAY_CYCLES = `RESET_DELAY_US * `CLK_MHZ,
   parameter int LONG_WINDOW_MS = `LONG_WINDOW_MS
) (
   // Clocks and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic spi_clk_i,
   // Serial port pins
   input wire logic chip_select_n_i,
   input wire logic spi_data_i,
   // Device context
   input wire wdog_pkg::sbc_mode_t sbc_mode_i,
   input wire logic dev_mode_i,
   input wire logic fail_input_disable_i,
   input wire logic reset_event_i,
   input wire logic can_wake_i,
   input wire logic lin_wake_i,
   input wire logic spi_fail_clear_i,
   // Reset and mode requests
   output logic reset_out_n_o,
   output logic restart_req_o,
   output logic normal_req_o,
   // Status
   output wdog_pkg::supervisor_ctrl_t ctrl_o,
   output logic stop_disable_step_one_o,
   output logic [1:0] service_failure_flags_o,
   output logic spi_fail_o,
   output logic watchdog_running_o,
   // Bus wake reaction
   output logic wake_irq_o,
   output logic can_receive_low_o,
   output logic lin_receive_low_o
);

   // ****************************************************************
   // Period decode
   // ****************************************************************
   function automatic logic [15:0] period_ms(input logic [2:0] code);
      unique case (code)
         3'h0: period_ms = 16'h000a;
         3'h1: period_ms = 16'h0014;
         3'h2: period_ms = 16'h0032;
         3'h3: period_ms = 16'h0064;
         3'h4: period_ms = 16'h00c8;
         3'h5: period_ms = 16'h01f4;
         default: period_ms = 16'h03e8;
      endcase
   endfunction : period_ms

   localparam logic [15:0] LONG_MS = 16'(LONG_WINDOW_MS);

   // ****************************************************************
   // Link domain: shift in frames
   // ****************************************************************
   logic [15:0] shift;
   logic [4:0] bit_cnt;

   always_ff @(posedge spi_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         shift <= 16'h0000;
         bit_cnt <= 5'h00;
      end else if (!chip_select_n_i) begin
         shift <= {shift[14:0], spi_data_i};
         bit_cnt <= bit_cnt + 5'h01;
      end
   end

   // ****************************************************************
   // Chip-select crossing and frame capture
   // ****************************************************************
   // Shift and bit count are static once chip select is high again.
   logic cs_meta;
   logic cs_sync;
   logic cs_prev;
   logic [4:0] last_cnt;
   logic cs_rise;
   logic frame_ok;
   logic [7:0] data;
   logic ctrl_wr;
   logic wake_wr;
   logic par_ok;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_prev <= 1'b1;
      end else begin
         cs_meta <= chip_select_n_i;
         cs_sync <= cs_meta;
         cs_prev <= cs_sync;
      end
   end

   assign cs_rise = cs_sync & ~cs_prev;
   assign frame_ok = cs_rise && (5'(bit_cnt - last_cnt) == `FRAME_BITS);
   assign data = shift[15:8];
   assign ctrl_wr = frame_ok && shift[`FRAME_WRITE_BIT]
                    && (shift[6:0] == `ADDR_SUPERVISOR_CTRL);
   assign wake_wr = frame_ok && shift[`FRAME_WRITE_BIT]
                    && (shift[6:0] == `ADDR_WAKE_CTRL_ONE);
   assign par_ok = ~^data;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         last_cnt <= 5'h00;
      end else if (cs_rise) begin
         last_cnt <= bit_cnt;
      end
   end

   // ****************************************************************
   // Mode qualifiers
   // ****************************************************************
   wdog_pkg::sbc_mode_t mode_prev;
   logic in_normal;
   logic in_stop;
   logic stop_off;
   logic service;
   logic stop_resume;
   logic bus_wake;
   logic enabled;
   logic limit_hit;

   assign in_normal = (sbc_mode_i == wdog_pkg::MODE_NORMAL);
   assign in_stop = (sbc_mode_i == wdog_pkg::MODE_STOP);
   assign stop_off = ctrl_o.stop_disable_step_zero & stop_disable_step_one_o;
   assign service = ctrl_wr && par_ok && !dev_mode_i
                    && (in_normal || in_stop || sbc_mode_i == wdog_pkg::MODE_INIT);
   assign stop_resume = (in_stop && stop_off && service)
                        || (mode_prev == wdog_pkg::MODE_STOP && in_normal);
   assign bus_wake = in_stop && stop_off && ctrl_o.restart_on_bus_wake
                     && (can_wake_i || lin_wake_i);
   assign enabled = !dev_mode_i && (in_normal || sbc_mode_i == wdog_pkg::MODE_INIT
                    || (in_stop && !stop_off));
   assign limit_hit = ctrl_o.reset_limit && (service_failure_flags_o == `FAIL_LIMIT);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_prev <= wdog_pkg::MODE_INIT;
      end else begin
         mode_prev <= sbc_mode_i;
      end
   end

   // ****************************************************************
   // Control register and stop-disable sequence
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_o <= `CTRL_RESET;
      end else begin
         if (ctrl_wr && par_ok && in_normal) begin
            ctrl_o.parity_result <= data[7];
            ctrl_o.period_select_field <= data[6:4];
            ctrl_o.reset_limit <= data[3];
            ctrl_o.restart_on_bus_wake <= data[2];
            ctrl_o.window_variant_select <= data[1];
            if (data[0] && ctrl_o.stop_disable_step_zero) begin
               ctrl_o.stop_disable_step_zero <= 1'b0;
            end else begin
               ctrl_o.stop_disable_step_zero <= data[0] & fail_input_disable_i;
            end
         end else if (stop_resume || bus_wake) begin
            ctrl_o.stop_disable_step_zero <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         stop_disable_step_one_o <= 1'b0;
      end else if (stop_resume || bus_wake) begin
         stop_disable_step_one_o <= 1'b0;
      end else if (wake_wr && in_normal) begin
         // A set without a valid first step is a sequence error
         stop_disable_step_one_o <= data[`WAKE_STEP_ONE_BIT]
            && ctrl_o.stop_disable_step_zero && fail_input_disable_i;
      end else if (ctrl_wr && par_ok && in_normal && data[0]
                   && ctrl_o.stop_disable_step_zero) begin
         stop_disable_step_one_o <= 1'b0;
      end
   end

   // ****************************************************************
   // Parity error flag
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         spi_fail_o <= 1'b0;
      end else if (ctrl_wr && !par_ok) begin
         spi_fail_o <= 1'b1;
      end else if (spi_fail_clear_i) begin
         spi_fail_o <= 1'b0;
      end
   end

   // ****************************************************************
   // Millisecond time base
   // ****************************************************************
   wdog_pkg::wd_state_t state;
   logic [31:0] tick_cnt;
   logic tick;
   logic [15:0] ms_cnt;
   logic [31:0] rst_cnt;
   logic restart_timer;
   logic expired;
   logic closed_end;
   logic [15:0] period;
   logic [15:0] closed;

   assign period = period_ms(ctrl_o.period_select_field);
   assign closed = 16'((32'(period) * `CLOSED_PERCENT) / 100);
   assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));
   assign expired = tick
                    && ((state == wdog_pkg::WD_LONG && ms_cnt == LONG_MS - 16'h0001)
                    || (state == wdog_pkg::WD_OPEN && ms_cnt == period - 16'h0001));
   assign closed_end = tick && state == wdog_pkg::WD_CLOSED
                       && ms_cnt == closed - 16'h0001;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tick_cnt <= 32'h0000_0000;
         ms_cnt <= 16'h0000;
      end else if (restart_timer) begin
         tick_cnt <= 32'h0000_0000;
         ms_cnt <= 16'h0000;
      end else if (tick) begin
         tick_cnt <= 32'h0000_0000;
         ms_cnt <= ms_cnt + 16'h0001;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
      end
   end

   // ****************************************************************
   // Watchdog state machine
   // ****************************************************************
   wdog_pkg::wd_state_t next_state;
   logic fail;

   always_comb begin
      next_state = state;
      fail = 1'b0;
      restart_timer = 1'b0;
      unique case (state)
         wdog_pkg::WD_OFF: begin
            if (enabled) begin
               next_state = wdog_pkg::WD_LONG;
               restart_timer = 1'b1;
            end
         end
         wdog_pkg::WD_LONG, wdog_pkg::WD_OPEN: begin
            if (service) begin
               next_state = ctrl_o.window_variant_select ? wdog_pkg::WD_CLOSED
                            : wdog_pkg::WD_OPEN;
               restart_timer = 1'b1;
            end else if (expired) begin
               fail = 1'b1;
            end
         end
         wdog_pkg::WD_CLOSED: begin
            if (service) begin
               fail = 1'b1;
            end else if (closed_end) begin
               next_state = wdog_pkg::WD_OPEN;
            end
         end
         wdog_pkg::WD_RESET: begin
            if (!reset_event_i && rst_cnt == 32'(RESET_DELAY_CYCLES - 1)) begin
               next_state = wdog_pkg::WD_LONG;
               restart_timer = 1'b1;
            end
         end
      endcase
      if (state != wdog_pkg::WD_RESET) begin
         if (reset_event_i) begin
            next_state = wdog_pkg::WD_RESET;
         end else if (fail && !limit_hit) begin
            next_state = wdog_pkg::WD_RESET;
         end else if (fail || stop_resume || bus_wake) begin
            next_state = wdog_pkg::WD_LONG;
            restart_timer = 1'b1;
         end else if (!enabled) begin
            next_state = wdog_pkg::WD_OFF;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= wdog_pkg::WD_OFF;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_cnt <= 32'h0000_0000;
      end else if (state != wdog_pkg::WD_RESET || reset_event_i) begin
         rst_cnt <= 32'h0000_0000;
      end else begin
         rst_cnt <= rst_cnt + 32'h0000_0001;
      end
   end

   // ****************************************************************
   // Reset output, mode requests and failure count
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reset_out_n_o <= 1'b1;
         restart_req_o <= 1'b0;
         normal_req_o <= 1'b0;
         watchdog_running_o <= 1'b0;
      end else begin
         reset_out_n_o <= (next_state != wdog_pkg::WD_RESET);
         restart_req_o <= fail && !limit_hit && !reset_event_i
                          && state != wdog_pkg::WD_RESET;
         normal_req_o <= (state == wdog_pkg::WD_RESET)
                         && (next_state == wdog_pkg::WD_LONG);
         watchdog_running_o <= (next_state != wdog_pkg::WD_OFF)
                               && (next_state != wdog_pkg::WD_RESET);
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         service_failure_flags_o <= 2'h0;
      end else if (fail && !limit_hit && state != wdog_pkg::WD_RESET) begin
         if (service_failure_flags_o != `FAIL_LIMIT) begin
            service_failure_flags_o <= service_failure_flags_o + 2'h1;
         end
      end else if (service && state != wdog_pkg::WD_CLOSED) begin
         service_failure_flags_o <= 2'h0;
      end
   end

   // ****************************************************************
   // Bus wake reaction
   // ****************************************************************
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wake_irq_o <= 1'b0;
         can_receive_low_o <= 1'b0;
         lin_receive_low_o <= 1'b0;
      end else begin
         wake_irq_o <= bus_wake;
         if (!in_stop) begin
            can_receive_low_o <= 1'b0;
            lin_receive_low_o <= 1'b0;
         end else if (bus_wake) begin
            can_receive_low_o <= can_wake_i | can_receive_low_o;
            lin_receive_low_o <= lin_wake_i | lin_receive_low_o;
         end
      end
   end

endmodule : window_timeout_watchdog
